/* File: pkg/eaa_pkg.sv */
// Constants and carrier types for the energy accumulation and event block.
// Assumes one 20 MHz clock shared with the upstream power datapath.
// Function
// - Line-cycle accumulation starts/stops on zero crossings
// - Half-cycle count is 16 bits, up to 65535
// - Count reached sets cycle-end flag, interrupt if unmasked
// - Next cycle starts at once, readout overwritten
// - Count write clears readout, restarts at crossing
// - Line and normal accumulation share scaled path
// - Disable bit blocks the cycle-end interrupt
// - Disable bit keeps readout and accumulator on write
// - Amp-hour select replaces apparent power everywhere
// - Amp-hour uses current 1 or half-sum
// - Current value gets two low zero bits
// - Amp-hour adds unsigned into 42-bit accumulator
// - One sample added every 230.4 microseconds
// - Amp-hour applies no-load threshold to current
// - Only the selected quantity is accumulated
// - Pulse rate follows the accumulated quantity
// - Two selectable captures latched each sample
// - Source code order: integrators, active, reactive, apparent
// - Active sign event on chosen transition only
// - Active half-full event in either direction
// - Active overflow or underflow raises event
// - Thirteen interrupt sources in total
package eaa_pkg;

    // Sample period and derived cycle count
    localparam real SAMPLE_US  = 230.4;
    localparam int  CLK_MHZ    = 20;
    localparam int  SAMPLE_CYC = int'(SAMPLE_US * CLK_MHZ);
    localparam int  TICK_W     = 13;

    // Datapath widths
    localparam int ACC_W  = 42;
    localparam int RD_W   = 24;
    localparam int RD_LSB = ACC_W - RD_W;
    localparam int PWR_W  = 25;
    localparam int RMS_W  = 23;
    localparam int HCC_W  = 16;
    localparam int SEL_W  = 3;
    localparam int NSRC   = 8;
    localparam int NIRQ   = 13;
    localparam int PH_W   = 32;

    // Flag positions within the interrupt vector
    localparam int F_ACT_SIGN = 0;
    localparam int F_ACT_HF   = 1;
    localparam int F_ACT_OF   = 2;
    localparam int F_APP_HF   = 8;
    localparam int F_APP_OF   = 9;
    localparam int F_APP_NL   = 10;
    localparam int F_CYC_END  = 11;
    localparam int F_WAVE     = 12;

    // No-load thresholds: apparent power, then amp-hour
    localparam logic [PWR_W-1:0] NL_AP_1 = 25'h0000275;
    localparam logic [PWR_W-1:0] NL_AP_2 = 25'h000013a;
    localparam logic [PWR_W-1:0] NL_AP_3 = 25'h000009d;
    localparam logic [PWR_W-1:0] NL_AH_1 = 25'h0000379;
    localparam logic [PWR_W-1:0] NL_AH_2 = 25'h00001bc;
    localparam logic [PWR_W-1:0] NL_AH_3 = 25'h00000de;

    // Pulse converter full-scale, arbitrary scale
    localparam logic [PH_W-1:0] PULSE_THRESH = 32'h01000000;

    typedef enum logic [1:0] {
        EAA_LC_WAIT = 2'b00,
        EAA_LC_RUN  = 2'b01
    } eaa_lc_t;

    typedef struct packed {
        logic             amp_hour_select;
        logic             wiring_mode;
        logic             cycle_end_disable;
        logic             active_polarity_select;
        logic [1:0]       noload_sel;
        logic [7:0]       apparent_energy_divider;
        logic [SEL_W-1:0] waveform_source_1;
        logic [SEL_W-1:0] waveform_source_2;
    } eaa_cfg_t;

    typedef struct packed {
        logic                       zero_cross;
        logic [RMS_W-1:0]           current_rms_1;
        logic [RMS_W-1:0]           current_rms_2;
        logic [PWR_W-1:0]           apparent_gain_1;
        logic [PWR_W-1:0]           apparent_gain_2;
        logic [PWR_W-1:0]           active_power;
        logic [NSRC-1:0][PWR_W-1:0] src;
    } eaa_dp_t;

endpackage

/* File: design/eaa_pulse_gen.sv */
// Energy-to-frequency converter for the energy pulse output.
// Assumes one quantity per sample strobe from the accumulation path.
`timescale 1ns/1ps
`default_nettype none
module eaa_pulse_gen #(
    parameter logic [eaa_pkg::PH_W-1:0] THRESH = eaa_pkg::PULSE_THRESH
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      add_vld,
    input  wire logic [eaa_pkg::PWR_W-1:0] add,
    output logic                           pulse
);

    typedef struct packed {
        logic [eaa_pkg::PH_W-1:0] ph;
        logic                     pulse;
    } eaa_pg_st_t;

    eaa_pg_st_t s;
    eaa_pg_st_t n;

    // Phase accumulator, remainder kept so no energy is lost
    always_comb
    begin
        n       = s;
        n.pulse = 1'b0;
        if (add_vld)
        begin
            n.ph = s.ph + {{(eaa_pkg::PH_W-eaa_pkg::PWR_W){1'b0}}, add};
            if (n.ph >= THRESH)
            begin
                n.ph    = n.ph - THRESH;
                n.pulse = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    assign pulse = s.pulse;

endmodule
`default_nettype wire

/* File: design/eaa_energy_events.sv */
// Apparent / amp-hour energy accumulation, line-cycle mode, waveform
// capture and power-unit event flags. Datapath inputs are same-clock logic.
`timescale 1ns/1ps
`default_nettype none
module eaa_energy_events #(
    parameter int SAMPLE_CYC = eaa_pkg::SAMPLE_CYC
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire eaa_pkg::eaa_cfg_t                cfg,
    input  wire eaa_pkg::eaa_dp_t                 dp,
    input  wire logic [eaa_pkg::HCC_W-1:0]        half_cycle_count,
    input  wire logic                             half_cycle_count_wr,
    input  wire logic                             apparent_energy_read_clear,
    input  wire logic [eaa_pkg::NIRQ-1:0]         irq_mask,
    input  wire logic [eaa_pkg::NIRQ-1:0]         irq_clear,
    input  wire logic [eaa_pkg::NIRQ-1:0]         ext_event,
    output logic [eaa_pkg::RD_W-1:0]              apparent_energy_readout,
    output logic [eaa_pkg::RD_W-1:0]              line_cycle_energy_readout,
    output logic [eaa_pkg::PWR_W-1:0]             waveform_capture_1,
    output logic [eaa_pkg::PWR_W-1:0]             waveform_capture_2,
    output logic [eaa_pkg::NIRQ-1:0]              irq_flags,
    output logic                                  irq,
    output logic                                  energy_pulse
);

    localparam int AW = eaa_pkg::ACC_W;
    localparam int PW = eaa_pkg::PWR_W;
    localparam logic [eaa_pkg::TICK_W-1:0] TICK_LAST = eaa_pkg::TICK_W'(SAMPLE_CYC - 1);

    typedef struct packed {
        logic [eaa_pkg::TICK_W-1:0] tick_cnt;
        eaa_pkg::eaa_lc_t           lc;
        logic [eaa_pkg::HCC_W-1:0]  half_cnt;
        logic [eaa_pkg::HCC_W-1:0]  hcc;
        logic [AW-1:0]              app_acc;
        logic [AW-1:0]              line_acc;
        logic [eaa_pkg::RD_W-1:0]   line_rd;
        logic [AW-1:0]              act_acc;
        logic                       act_neg;
        logic [eaa_pkg::NIRQ-1:0]   flag;
        logic                       irq;
        logic [PW-1:0]              cap1;
        logic [PW-1:0]              cap2;
    } eaa_st_t;

    eaa_st_t s;
    eaa_st_t n;

    // No-load threshold lookup; code 0 disables detection
    function automatic logic [PW-1:0] noload_thr(input logic [1:0] sel, input logic ah);
        logic [PW-1:0] t;
        t = '0;
        case (sel)
            2'b01:   t = ah ? eaa_pkg::NL_AH_1 : eaa_pkg::NL_AP_1;
            2'b10:   t = ah ? eaa_pkg::NL_AH_2 : eaa_pkg::NL_AP_2;
            2'b11:   t = ah ? eaa_pkg::NL_AH_3 : eaa_pkg::NL_AP_3;
            default: t = '0;
        endcase
        return t;
    endfunction

    // Half of a two-channel sum, or channel 1 alone in two-wire mode
    function automatic logic [PW-1:0] pick(input logic three, input logic [PW-1:0] a, input logic [PW-1:0] b);
        logic [PW:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return three ? sum[PW:1] : a;
    endfunction

    logic          tick;
    logic [PW-1:0] ah_qty;
    logic [PW-1:0] ah_half;
    logic [PW-1:0] qty;
    logic [PW-1:0] scaled;
    logic [PW-1:0] add;
    logic [7:0]    div;
    logic          noload;
    logic [AW-1:0] app_base;
    logic [AW:0]   app_sum;
    logic [AW-1:0] act_ext;
    logic [AW-1:0] act_sum;
    logic          act_of;
    logic          act_hf;
    logic          sign_evt;
    logic          cyc_end;
    logic [eaa_pkg::HCC_W-1:0] half_nxt;
    logic [eaa_pkg::NIRQ-1:0]  set;

    // Selected quantity, scaling and no-load gating; one shared path
    always_comb
    begin
        tick   = (s.tick_cnt == TICK_LAST);
        ah_half = pick(cfg.wiring_mode, PW'(dp.current_rms_1), PW'(dp.current_rms_2));
        ah_qty  = {ah_half[eaa_pkg::RMS_W-1:0], 2'b00};
        qty    = cfg.amp_hour_select ? ah_qty
                                     : pick(cfg.wiring_mode, dp.apparent_gain_1, dp.apparent_gain_2);
        div    = (cfg.apparent_energy_divider == 8'h00) ? 8'h01 : cfg.apparent_energy_divider;
        scaled = qty / PW'(div);
        noload = (qty < noload_thr(cfg.noload_sel, cfg.amp_hour_select));
        add    = noload ? '0 : scaled;
    end

    // Unsigned apparent / amp-hour accumulation with read-clear of top bits
    always_comb
    begin
        app_base = apparent_energy_read_clear ? {{eaa_pkg::RD_W{1'b0}}, s.app_acc[eaa_pkg::RD_LSB-1:0]} : s.app_acc;
        app_sum  = {1'b0, app_base} + {{(AW+1-PW){1'b0}}, add};
    end

    // Signed active energy; half-full is the top two bits parting
    always_comb
    begin
        act_ext  = {{(AW-PW){dp.active_power[PW-1]}}, dp.active_power};
        act_sum  = s.act_acc + act_ext;
        act_of   = (s.act_acc[AW-1] == act_ext[AW-1]) && (act_sum[AW-1] != s.act_acc[AW-1]);
        act_hf   = (s.act_acc[AW-1] == s.act_acc[AW-2]) && (act_sum[AW-1] != act_sum[AW-2]) && !act_of;
        sign_evt = cfg.active_polarity_select ? (s.act_neg && !dp.active_power[PW-1])
                                              : (!s.act_neg && dp.active_power[PW-1]);
    end

    // Line-cycle end: programmed half-cycle count hit on a crossing
    always_comb
    begin
        half_nxt = s.half_cnt + 16'h0001;
        cyc_end  = (s.lc == eaa_pkg::EAA_LC_RUN) && dp.zero_cross
                   && (s.hcc != 16'h0000) && (half_nxt == s.hcc);
    end

    // Next-state assembly
    always_comb
    begin
        n          = s;
        set        = '0;
        n.tick_cnt = tick ? '0 : s.tick_cnt + 13'h0001;
        if (tick)
        begin
            n.app_acc  = app_sum[AW-1:0];
            n.act_acc  = act_sum;
            n.act_neg  = dp.active_power[PW-1];
            n.cap1     = dp.src[cfg.waveform_source_1];
            n.cap2     = dp.src[cfg.waveform_source_2];
            set[eaa_pkg::F_APP_OF]   = app_sum[AW];
            set[eaa_pkg::F_APP_HF]   = !app_base[AW-1] && app_sum[AW-1];
            set[eaa_pkg::F_APP_NL]   = noload;
            set[eaa_pkg::F_ACT_OF]   = act_of;
            set[eaa_pkg::F_ACT_HF]   = act_hf;
            set[eaa_pkg::F_ACT_SIGN] = sign_evt;
            set[eaa_pkg::F_WAVE]     = 1'b1;
            if (s.lc == eaa_pkg::EAA_LC_RUN)
                n.line_acc = s.line_acc + {{(AW-PW){1'b0}}, add};
        end
        else
        begin
            n.app_acc = app_base;
        end
        case (s.lc)
            eaa_pkg::EAA_LC_WAIT:
            begin
                if (dp.zero_cross)
                begin
                    n.lc       = eaa_pkg::EAA_LC_RUN;
                    n.half_cnt = '0;
                    n.line_acc = '0;
                end
            end
            eaa_pkg::EAA_LC_RUN:
            begin
                if (cyc_end)
                begin
                    n.line_rd  = n.line_acc[AW-1:eaa_pkg::RD_LSB];
                    n.line_acc = '0;
                    n.half_cnt = '0;
                    set[eaa_pkg::F_CYC_END] = !cfg.cycle_end_disable;
                end
                else if (dp.zero_cross)
                    n.half_cnt = half_nxt;
            end
            default: n.lc = eaa_pkg::EAA_LC_WAIT;
        endcase
        // Unless disabled, a count write clears what a coincident cycle end latches; the flag still sets
        if (half_cycle_count_wr)
        begin
            n.hcc = half_cycle_count;
            if (!cfg.cycle_end_disable)
            begin
                n.line_rd  = '0;
                n.line_acc = '0;
                n.half_cnt = '0;
                n.lc       = eaa_pkg::EAA_LC_WAIT;
            end
        end
        // Set beats clear so no event is lost
        n.flag = (s.flag & ~irq_clear) | set | ext_event;
        n.irq  = |(n.flag & ~irq_mask);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    // Frequency conversion sees the same gated quantity as the accumulator
    eaa_pulse_gen u_pulse (
        .clk     (clk),
        .rst     (rst),
        .add_vld (tick),
        .add     (add),
        .pulse   (energy_pulse)
    );

    assign apparent_energy_readout   = s.app_acc[AW-1:eaa_pkg::RD_LSB];
    assign line_cycle_energy_readout = s.line_rd;
    assign waveform_capture_1        = s.cap1;
    assign waveform_capture_2        = s.cap2;
    assign irq_flags                 = s.flag;
    assign irq                       = s.irq;

    // Independent 43-bit view of the active sum, read by the checks only
    logic [AW:0] act_wide;
    assign act_wide = {s.act_acc[AW-1], s.act_acc} + {act_ext[AW-1], act_ext};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence seq_count_write;
        half_cycle_count_wr && !cfg.cycle_end_disable;
    endsequence

    sequence seq_wait_state;
        (s.lc == eaa_pkg::EAA_LC_WAIT) && (s.line_rd == '0);
    endsequence

    sequence seq_cycle_end;
        cyc_end && !cfg.cycle_end_disable;
    endsequence

    // Sample strobe restarts the counter at zero and does not repeat on the next cycle
    a_tick_restart: assert property (tick |=> s.tick_cnt == 0 ##1 !tick)
        else $error("sample strobe period wrong");
    // Unmasked cycle end raises the interrupt on the same edge as the flag
    a_cycle_end_set: assert property (seq_cycle_end |=> s.flag[eaa_pkg::F_CYC_END]
        && (s.irq || $past(irq_mask[eaa_pkg::F_CYC_END])))
        else $error("cycle end did not flag");
    // Disabled detection never sets the cycle-end flag by itself
    a_disable_quiet: assert property (cfg.cycle_end_disable && !s.flag[eaa_pkg::F_CYC_END]
        && !ext_event[eaa_pkg::F_CYC_END] |=> !s.flag[eaa_pkg::F_CYC_END])
        else $error("cycle end flagged while disabled");
    // Count write empties the readout and waits for a crossing
    a_write_clears: assert property (seq_count_write |=> seq_wait_state)
        else $error("count write did not restart");
    // With detection disabled a count write leaves the readout alone
    a_write_keeps: assert property (half_cycle_count_wr && cfg.cycle_end_disable && !cyc_end
        |=> $stable(s.line_rd))
        else $error("readout cleared while disabled");
    // Sticky flag survives until software clears it
    a_flag_hold: assert property (s.flag[eaa_pkg::F_ACT_SIGN] && !irq_clear[eaa_pkg::F_ACT_SIGN]
        |=> s.flag[eaa_pkg::F_ACT_SIGN])
        else $error("flag dropped without clear");
    // Chosen sign transition at a strobe is flagged
    a_sign_event: assert property (tick && sign_evt |=> s.flag[eaa_pkg::F_ACT_SIGN])
        else $error("sign change not flagged");
    // First capture follows its source code
    a_capture_src: assert property (tick |=> s.cap1 == $past(dp.src[cfg.waveform_source_1]))
        else $error("waveform capture wrong");
    // Second capture follows its own source code
    a_capture_second: assert property (tick |=> s.cap2 == $past(dp.src[cfg.waveform_source_2]))
        else $error("second waveform capture wrong");
    // Every sample strobe announces fresh captures
    a_wave_flag: assert property (tick |=> s.flag[eaa_pkg::F_WAVE])
        else $error("waveform update not flagged");
    // Interrupt line is the current flags unmasked by the mask of the previous edge
    a_irq_mask: assert property (s.irq == |(s.flag & ~$past(irq_mask)))
        else $error("interrupt output mismatch");
    // Cycle end copies the line accumulator and starts over from zero
    a_line_latch: assert property (cyc_end && !half_cycle_count_wr && !tick
        |=> s.line_rd == $past(s.line_acc[AW-1:eaa_pkg::RD_LSB]) && s.line_acc == '0)
        else $error("line readout not latched");
    // Line accumulation adds exactly what the main accumulator adds
    a_line_path: assert property (tick && (s.lc == eaa_pkg::EAA_LC_RUN) && !cyc_end
        && !half_cycle_count_wr |=> s.line_acc == $past(s.line_acc) + {{(AW-PW){1'b0}}, $past(add)})
        else $error("line accumulation path differs");
    // Signed wrap of the active accumulator is flagged
    a_act_overflow: assert property (tick && (act_wide[AW] != act_wide[AW-1])
        |=> s.flag[eaa_pkg::F_ACT_OF])
        else $error("active overflow not flagged");
    // Crossing half scale in either direction is flagged
    a_act_half_full: assert property (tick && (s.act_acc[AW-1] == s.act_acc[AW-2])
        && (act_wide[AW-1] != act_wide[AW-2]) && (act_wide[AW] == act_wide[AW-1])
        |=> s.flag[eaa_pkg::F_ACT_HF])
        else $error("active half-full not flagged");
    // Below the no-load level nothing is added, but the event is kept
    a_noload_gate: assert property (tick && noload
        |=> s.flag[eaa_pkg::F_APP_NL] && s.app_acc == $past(app_base))
        else $error("no-load sample was accumulated");
    // Apparent accumulator is a plain unsigned 42-bit sum
    a_unsigned_add: assert property (tick
        |=> s.app_acc == $past(app_base) + {{(AW-PW){1'b0}}, $past(add)})
        else $error("unsigned accumulation wrong");
    // Energy pulse only follows a sample strobe
    a_pulse_tick: assert property (energy_pulse |-> $past(tick))
        else $error("energy pulse without sample");
    // Two-wire amp-hour quantity is current 1 with two low zeros
    a_amp_extend: assert property (cfg.amp_hour_select && !cfg.wiring_mode
        |-> qty == {dp.current_rms_1, 2'b00})
        else $error("amp-hour quantity wrong");
    // Two-wire apparent mode takes the first gain output unchanged
    a_apparent_path: assert property (!cfg.amp_hour_select && !cfg.wiring_mode
        |-> qty == dp.apparent_gain_1)
        else $error("apparent quantity wrong");

endmodule
`default_nettype wire

/* File: bench/eaa_dp_model.sv */
// Stand-in for the upstream power, RMS and zero-crossing datapath.
// Assumes the bench hands it values off the rising edge; same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module eaa_dp_model (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire eaa_pkg::eaa_dp_t vals,
    input  wire logic             zc_req,
    output var eaa_pkg::eaa_dp_t  dp
);
    // Registered like the real stages, so values only move on clock edges
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dp <= '0;
        end
        else
        begin
            dp            <= vals;
            dp.zero_cross <= zc_req; // One pulse per requested crossing
        end
    end
endmodule
`default_nettype wire

/* File: bench/energy_accumulation_events_test.sv */
// Self-checking bench for the energy accumulation and event block.
// Assumes the upstream stand-in eaa_dp_model and a shortened sample period.
`timescale 1ns/1ps
`default_nettype none
module energy_accumulation_events_test;
    localparam int SC = 16;
    typedef struct packed {
        logic [23:0] ard;
        logic [23:0] lrd;
        logic [24:0] c1;
        logic [24:0] c2;
        logic [12:0] fl;
        logic        irq;
    } eaa_note_t;
    // Stimulus, outputs and the bench's own model state
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    eaa_pkg::eaa_cfg_t cfg = '0;
    eaa_pkg::eaa_dp_t  vals = '0;
    eaa_pkg::eaa_dp_t  dp;
    logic              zc_req = 1'b0, hcc_wr = 1'b0, rd_clr = 1'b0;
    logic [15:0]       hcc = '0;
    logic [12:0]       mask = '0, clr = '0, ext = '0;
    logic [23:0]       app_rd, line_rd;
    logic [24:0]       cap1, cap2;
    logic [12:0]       flags;
    logic              irq, pulse;
    logic [31:0]       seed = 32'h478f1855;
    logic [41:0]       m_acc = '0, m_lacc = '0;
    logic [23:0]       m_lrd = '0;
    logic [15:0]       m_hcc = '0, m_cnt = '0;
    logic              m_run = 1'b0, m_neg = 1'b0, wave_prev = 1'b0;
    logic [31:0]       m_ph = '0;
    int                m_pulses = 0, got_pulses = 0, cycles = 0, last_pop = 0;
    int                bad_count = 0;
    int                checks_done = 0;
    eaa_note_t         notes[$];

    always #25 clk = ~clk;

    eaa_dp_model i_dp (
        .clk    (clk),
        .rst    (rst),
        .vals   (vals),
        .zc_req (zc_req),
        .dp     (dp)
    );

    eaa_energy_events #(
        .SAMPLE_CYC (SC)
    ) i_dut (
        .clk                        (clk),
        .rst                        (rst),
        .cfg                        (cfg),
        .dp                         (dp),
        .half_cycle_count           (hcc),
        .half_cycle_count_wr        (hcc_wr),
        .apparent_energy_read_clear (rd_clr),
        .irq_mask                   (mask),
        .irq_clear                  (clr),
        .ext_event                  (ext),
        .apparent_energy_readout    (app_rd),
        .line_cycle_energy_readout  (line_rd),
        .waveform_capture_1         (cap1),
        .waveform_capture_2         (cap2),
        .irq_flags                  (flags),
        .irq                        (irq),
        .energy_pulse               (pulse)
    );

    // Xorshift source, fixed start so every run is the same
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Comparisons, one per kind of result
    task automatic miss(input string what);
        bad_count++;
        $display("CHECK FAILED at %0t: %s", $time, what);
    endtask
    task automatic cmp_rd(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp)
            miss($sformatf("readout %h, expected %h", got, exp));
    endtask
    task automatic cmp_cap(input logic [24:0] got, input logic [24:0] exp);
        checks_done++;
        if (got !== exp)
            miss($sformatf("capture %h, expected %h", got, exp));
    endtask
    task automatic cmp_flg(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp)
            miss($sformatf("flags %h, expected %h", got, exp));
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One sample period of stimulus plus the expected result of its tick
    task automatic step(input int i);
        logic [31:0] r;
        logic [25:0] q;
        logic        cyc;
        logic        fire;
        eaa_note_t   n;
        r = rnd();
        clr = 13'h1fff;
        ext = {5'h0, r[7:3], 3'h0};
        mask = r[20:8];
        hcc_wr = (r[23:21] == 3'h0);
        zc_req = r[24];
        rd_clr = (r[27:25] == 3'h0);
        hcc = hcc_wr ? ((r[29:28] == 2'h3) ? 16'hffff : {14'h0, r[29:28]}) : hcc;
        cfg.amp_hour_select = (r[30] && i < 40) || i == 40; // Step 40 is an amp-hour no-load period
        cfg.wiring_mode = r[31] && i < 40;
        r = rnd();
        cfg.cycle_end_disable = (r[1:0] == 2'h0);
        cfg.noload_sel = (i < 40) ? r[3:2] : 2'h1;
        cfg.apparent_energy_divider = {6'h0, r[5:4]};
        cfg.active_polarity_select = (i >= 43);
        cfg.waveform_source_1 = 3'(i);
        cfg.waveform_source_2 = r[8:6];
        vals.active_power = (i > 40 && i[0]) ? 25'h1f00000 : {1'b0, r[31:8]};
        r = rnd();
        vals.apparent_gain_1 = (i < 40) ? {3'h1, r[21:0]} : 25'h10; // Tiny value sits under no-load
        vals.current_rms_1 = (i == 40) ? 23'h10 : {1'b1, r[31:10]};
        r = rnd();
        vals.apparent_gain_2 = {3'h1, r[21:0]};
        vals.current_rms_2 = {1'b1, r[31:10]};
        for (int k = 0; k < 8; k++)
            vals.src[k] = 25'(rnd());
        // Count write lands one edge before the crossing it goes with
        if (hcc_wr && !cfg.cycle_end_disable)
        begin
            m_lrd = '0;
            m_run = 1'b0;
        end
        m_hcc = hcc;
        cyc = 1'b0;
        if (zc_req && !m_run)
        begin
            m_run = 1'b1;
            m_cnt = '0;
            m_lacc = '0;
        end
        else if (zc_req && m_hcc != 16'h0 && m_cnt + 1 == m_hcc)
        begin
            m_lrd = m_lacc[41:18];
            m_lacc = '0;
            m_cnt = '0;
            cyc = !cfg.cycle_end_disable;
        end
        else if (zc_req)
            m_cnt++;
        // Sample quantity; no-load periods add nothing anywhere
        q = cfg.amp_hour_select ? 26'(vals.current_rms_1) << 2 : 26'(vals.apparent_gain_1);
        if (cfg.wiring_mode)
            q = cfg.amp_hour_select ? ((26'(vals.current_rms_1) + vals.current_rms_2) >> 1) << 2
                                    : (26'(vals.apparent_gain_1) + vals.apparent_gain_2) >> 1;
        if (i >= 40)
            q = '0;
        // Pulse converter is fed the scaled quantity, same as the accumulator
        if (cfg.apparent_energy_divider > 8'h1)
            q = q / 26'(cfg.apparent_energy_divider);
        m_ph = m_ph + 32'(q);
        if (m_ph >= eaa_pkg::PULSE_THRESH)
        begin
            m_ph = m_ph - eaa_pkg::PULSE_THRESH;
            m_pulses++;
        end
        m_acc = {rd_clr ? 24'h0 : m_acc[41:18], m_acc[17:0]} + 42'(q);
        m_lacc = m_run ? m_lacc + 42'(q) : m_lacc;
        fire = cfg.active_polarity_select ? (m_neg && !vals.active_power[24]) : (!m_neg && vals.active_power[24]);
        m_neg = vals.active_power[24];
        n.ard = m_acc[41:18];
        n.lrd = m_lrd;
        n.c1 = vals.src[cfg.waveform_source_1];
        n.c2 = vals.src[cfg.waveform_source_2];
        n.fl = {1'b1, cyc, (i >= 40), 2'h0, ext[7:3], 2'h0, fire};
        n.irq = |(n.fl & ~mask);
        notes.push_back(n);
    endtask

    // Retire the oldest note when a waveform update shows up
    task automatic retire();
        eaa_note_t n;
        if (notes.size() == 0)
        begin
            miss("update with no pending note");
            return;
        end
        n = notes.pop_front();
        if (last_pop != 0)
            cmp_rd(24'(cycles - last_pop), 24'(SC));
        last_pop = cycles;
        cmp_rd(app_rd, n.ard);
        cmp_rd(line_rd, n.lrd);
        cmp_cap(cap1, n.c1);
        cmp_cap(cap2, n.c2);
        cmp_flg(flags, n.fl);
        cmp_flg({12'h0, irq}, {12'h0, n.irq});
    endtask

    // Output watcher, pulse counter and hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (pulse === 1'b1)
            got_pulses++;
        if (!rst && flags[eaa_pkg::F_WAVE] === 1'b1 && !wave_prev)
            retire();
        wave_prev = (flags[eaa_pkg::F_WAVE] === 1'b1);
        if (cycles == 3000)
        begin
            miss("run did not finish in time");
            finish_test();
        end
    end

    // Driver: random periods, then no-load and sign-change periods
    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 45; i++)
        begin
            step(i);
            @(negedge clk);
            clr = '0;
            ext = '0;
            zc_req = 1'b0;
            hcc_wr = 1'b0;
            rd_clr = 1'b0;
            while (flags[eaa_pkg::F_WAVE] !== 1'b1)
                @(negedge clk);
        end
        repeat (2) @(negedge clk);
        cmp_rd(24'(got_pulses), 24'(m_pulses));
        finish_test();
    end
endmodule
`default_nettype wire
